// ### src/teg_cyc_counter.sv
`timescale 1ns/1ps
`default_nettype none
module teg_cyc_counter
  import teg_pkg::*;
#(
  parameter int W = CC_WIDTH
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  // Control
  input  wire logic         restart_i,
  input  wire logic         mark_i,
  // Result
  output logic [W-1:0]      count_o
);
  logic [W-1:0] run;
  logic [W-1:0] next_run;
  logic [W-1:0] next_count;

  // Counts cycles between two counted commits; saturates rather than wraps
  always_comb begin
    next_run   = (&run) ? run : run + 1'b1;
    next_count = count_o;
    if (restart_i) begin
      next_run = '0;
    end else if (mark_i) begin
      next_count = next_run;
      next_run   = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      run     <= '0;
      count_o <= '0;
    end else begin
      run     <= next_run;
      count_o <= next_count;
    end
  end
endmodule
`default_nettype wire

// ### src/teg_pkg.sv
package teg_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ID     = 8'h08;
  localparam logic [7:0] REG_COUNT  = 8'h0c;

  // Control register fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_V11_BIT = 1;
  localparam int CTRL_TSL_BIT = 2;
  localparam int CTRL_TSH_BIT = 3;
  localparam int CTRL_WIDTH   = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Identification field position
  localparam int ID_TSFLOW_BIT = 0;

  // Exception type carried by a reset-type exception element
  localparam logic [7:0] EXC_PE_RESET = 8'h01;

  // Instruction set codes, three supported sets
  localparam logic [1:0] ISET_WIDE   = 2'h0;
  localparam logic [1:0] ISET_NARROW = 2'h1;
  localparam logic [1:0] ISET_MIXED  = 2'h2;

  // Cycle counter width
  localparam int CC_WIDTH = 32;

  typedef enum logic [3:0] {
    el_trace_on, el_target, el_context, el_atom_e, el_atom_n,
    el_src_addr, el_count, el_exception, el_tstart, el_commit,
    el_cyc_count, el_timestamp
  } teg_elem_t;

  typedef enum logic [2:0] {
    ck_atom, ck_src, ck_count, ck_exc, ck_tstart, ck_commit, ck_ts
  } teg_kind_t;

endpackage

// ### src/teg_top.sv
// Notes on behaviour
// - Warm reset emits a reset exception element
// - Reset exception: unknown address, context, no instructions
// - Source address: final flow instruction taken
// - Source address carries set and address, flow
// - Count element: optional count, else unknown
// - Count elements leave in program order
// - Count never exceptional; return ends it
// - Barrier ends count when context changes
// - New context after count gets context element
// - Unsynchronised change: count ends in old context
// - Trace-on element inserted after every gap
// - Target address follows trace-on before flow
// - Context after trace-on unless unchanged
// - First trace-on always gets its context
// - Target carries set, address, in order
// - Target may be corrected before next flow
// - Context carries security, level, width, identifiers
// - Cycle count ties to latest counted commit
// - Timestamp zero means unknown
// - Revision feature with marker: marker time
// - Otherwise time of latest flow element
// - Identification flag decides transaction start flow
// - Flow elements in sequential execution order
// - Atom executed means taken, else not taken
`timescale 1ns/1ps
`default_nettype none
module teg_top
  import teg_pkg::*;
#(
  parameter int  AW      = 64,
  parameter int  CW      = 8,
  parameter bit  TS_FLOW = 1'b1
) (
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          reset_i,
  // Wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic [31:0]        dat_o,
  output logic               ack_o,
  // Core execution and commit requests
  input  wire logic          core_valid_i,
  input  wire teg_kind_t     core_kind_i,
  input  wire logic          core_taken_i,
  input  wire logic [AW-1:0] core_addr_i,
  input  wire logic [1:0]    core_iset_i,
  input  wire logic [CW-1:0] core_count_i,
  input  wire logic          core_count_known_i,
  input  wire logic          core_new_ctx_i,
  input  wire logic [7:0]    core_exc_type_i,
  input  wire logic          core_cc_i,
  output logic               core_ready_o,
  // Core state
  input  wire logic          core_active_i,
  input  wire logic          core_gap_i,
  input  wire logic          core_warm_reset_i,
  input  wire logic          core_ts_mark_i,
  input  wire logic [AW-1:0] core_next_addr_i,
  input  wire logic [1:0]    core_next_iset_i,
  input  wire logic          ctx_secure_i,
  input  wire logic [1:0]    ctx_level_i,
  input  wire logic          ctx_wide_i,
  input  wire logic [31:0]   ctx_id_i,
  input  wire logic [31:0]   ctx_vid_i,
  // Timestamp sources
  input  wire logic [63:0]   ts_phys_i,
  input  wire logic [63:0]   ts_virt_i,
  // Element stream to the encoder
  output logic               elem_valid_o,
  input  wire logic          elem_ready_i,
  output teg_elem_t          elem_type_o,
  output logic [AW-1:0]      elem_addr_o,
  output logic [1:0]         elem_iset_o,
  output logic [63:0]        elem_payload_o,
  output logic [3:0]         elem_ctx_o,
  output logic               elem_unknown_o
);

  typedef enum logic [2:0] {
    st_idle, st_reset, st_on, st_ctx, st_tgt, st_run, st_cc
  } teg_state_t;

  // Bus registers
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [CTRL_WIDTH-1:0] next_ctrl;
  logic [31:0]           next_dat;
  logic                  next_ack;
  logic [31:0]           elem_cnt;
  logic [31:0]           next_elem_cnt;
  logic [31:0]           wr_mask;

  // Sequencer and output stage
  teg_state_t    state;
  teg_state_t    next_state;
  logic          next_valid;
  teg_elem_t     next_type;
  logic [AW-1:0] next_addr;
  logic [1:0]    next_iset;
  logic [63:0]   next_payload;
  logic [3:0]    next_ctx;
  logic          next_unknown;

  // History kept for ordering decisions
  logic          first_done;
  logic          next_first_done;
  logic [67:0]   last_ctx;
  logic [67:0]   next_last_ctx;
  logic          ctx_owed;
  logic          next_ctx_owed;
  logic [63:0]   flow_time;
  logic [63:0]   next_flow_time;
  logic [63:0]   mark_time;
  logic [63:0]   next_mark_time;
  logic          mark_seen;
  logic          next_mark_seen;

  logic          tracing;
  logic          out_free;
  logic          take;
  logic          is_flow;
  logic          bus_hit;
  logic [63:0]   ts_now;
  logic [67:0]   ctx_now;
  logic [CC_WIDTH-1:0] cc_value;

  function automatic logic [31:0] wmask(input logic [3:0] s);
    wmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  assign tracing  = ctrl[CTRL_EN_BIT] & core_active_i;
  assign out_free = !elem_valid_o || elem_ready_i;
  assign core_ready_o = (state == st_run) ? out_free : (state == st_idle);
  assign take     = core_valid_i && core_ready_o && state == st_run;
  assign bus_hit  = cyc_i && stb_i && !ack_o;
  assign wr_mask  = wmask(sel_i);
  assign ctx_now  = {ctx_vid_i, ctx_id_i, ctx_secure_i, ctx_level_i, ctx_wide_i};
  // Either select bit moves the source to the virtual counter
  assign ts_now   = (ctrl[CTRL_TSL_BIT] | ctrl[CTRL_TSH_BIT]) ? ts_virt_i : ts_phys_i;
  // Transaction start counts as flow only when the identification flag says so
  assign is_flow  = core_kind_i != ck_commit && core_kind_i != ck_ts
                 && (core_kind_i != ck_tstart || TS_FLOW);

  teg_cyc_counter #(.W(CC_WIDTH)) u_cc (
    .mclk_i    (mclk_i),
    .reset_i   (reset_i),
    .restart_i (state == st_on),
    .mark_i    (take && core_kind_i == ck_commit && core_cc_i),
    .count_o   (cc_value)
  );

  // Wishbone slave: one wait state, unmapped reads return zero
  always_comb begin
    next_ctrl     = ctrl;
    next_dat      = dat_o;
    next_ack      = bus_hit;
    next_elem_cnt = elem_cnt + {31'h0, elem_valid_o & elem_ready_i};
    // Write lands on the edge that completes the cycle, when the master sees ack
    if (cyc_i && stb_i && ack_o && we_i && adr_i == REG_CTRL) begin
      next_ctrl = (ctrl & ~wr_mask[CTRL_WIDTH-1:0]) | (dat_i[CTRL_WIDTH-1:0] & wr_mask[CTRL_WIDTH-1:0]);
    end
    if (bus_hit && !we_i) begin
      case (adr_i)
        REG_CTRL:   next_dat = {{(32-CTRL_WIDTH){1'b0}}, ctrl};
        REG_STATUS: next_dat = {25'h0, mark_seen, first_done, tracing, 1'b0, state};
        REG_ID:     next_dat = {31'h0, TS_FLOW};
        REG_COUNT:  next_dat = elem_cnt;
        default:    next_dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl     <= CTRL_RESET;
      dat_o    <= 32'h0;
      ack_o    <= 1'b0;
      elem_cnt <= 32'h0;
    end else begin
      ctrl     <= next_ctrl;
      dat_o    <= next_dat;
      ack_o    <= next_ack;
      elem_cnt <= next_elem_cnt;
    end
  end

  // Sequencer: gap handling, one element per accepted request; counted commits add a cycle count, new-context counts a target and context
  always_comb begin
    next_state   = state;
    next_valid   = elem_valid_o && !elem_ready_i;
    next_type    = elem_type_o;
    next_addr    = elem_addr_o;
    next_iset    = elem_iset_o;
    next_payload = elem_payload_o;
    next_ctx     = elem_ctx_o;
    next_unknown = elem_unknown_o;
    next_first_done = first_done;
    next_last_ctx   = last_ctx;
    next_ctx_owed   = ctx_owed;
    if (!tracing) begin
      next_state = st_idle;
    end else if (core_warm_reset_i && state != st_idle) begin
      next_state = st_reset;
    end else if (core_gap_i || state == st_idle) begin
      next_state = st_on;
    end else if (out_free) begin
      case (state)
        st_reset: begin
          next_valid   = 1'b1;
          next_type    = el_exception;
          next_payload = {56'h0, EXC_PE_RESET};
          next_addr    = '0;
          next_unknown = 1'b1;
          next_state   = st_on;
        end
        st_on: begin
          next_valid = 1'b1;
          next_type  = el_trace_on;
          next_state = (!first_done || ctx_now != last_ctx) ? st_ctx : st_tgt;
        end
        st_ctx: begin
          next_valid      = 1'b1;
          next_type       = el_context;
          next_payload    = ctx_now[67:4];
          next_ctx        = ctx_now[3:0];
          next_unknown    = 1'b0;
          next_last_ctx   = ctx_now;
          next_first_done = 1'b1;
          next_state      = ctx_owed ? st_run : st_tgt;
          next_ctx_owed   = 1'b0;
        end
        st_tgt: begin
          // A single target is sent; correction is never needed here
          next_valid = 1'b1;
          next_type  = el_target;
          next_addr  = core_next_addr_i;
          next_iset  = core_next_iset_i;
          next_state = st_run;
        end
        st_cc: begin
          next_valid   = 1'b1;
          next_type    = el_cyc_count;
          next_payload = {{(64-CC_WIDTH){1'b0}}, cc_value};
          next_state   = st_run;
        end
        st_run: begin
          if (core_valid_i) begin
            next_valid   = 1'b1;
            next_unknown = 1'b0;
            next_addr    = core_addr_i;
            next_iset    = core_iset_i;
            next_payload = 64'h0;
            case (core_kind_i)
              ck_atom:   next_type = core_taken_i ? el_atom_e : el_atom_n;
              ck_src:    next_type = el_src_addr;
              ck_exc: begin
                next_type    = el_exception;
                next_payload = {56'h0, core_exc_type_i};
              end
              ck_count: begin
                // Core closes the count at a taken return or a barrier
                next_type    = el_count;
                next_payload = {{(64-CW){1'b0}}, core_count_i};
                next_unknown = !core_count_known_i;
                if (core_new_ctx_i) begin
                  next_ctx_owed = 1'b1;
                  next_state    = st_tgt;
                end
              end
              ck_tstart: next_type = el_tstart;
              ck_commit: begin
                next_type = el_commit;
                if (core_cc_i) begin
                  next_state = st_cc;
                end
              end
              ck_ts: begin
                next_type = el_timestamp;
                next_payload = (ctrl[CTRL_V11_BIT] && mark_seen) ? mark_time : flow_time;
              end
              default:   next_valid = 1'b0;
            endcase
          end
        end
        default: next_state = st_idle;
      endcase
    end
    // After a count the owed context follows its target
    if (state == st_tgt && out_free && ctx_owed && tracing && !core_gap_i
        && !core_warm_reset_i) begin
      next_state = st_ctx;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state          <= st_idle;
      elem_valid_o   <= 1'b0;
      elem_type_o    <= el_trace_on;
      elem_addr_o    <= '0;
      elem_iset_o    <= ISET_WIDE;
      elem_payload_o <= 64'h0;
      elem_ctx_o     <= 4'h0;
      elem_unknown_o <= 1'b0;
      first_done     <= 1'b0;
      last_ctx       <= '0;
      ctx_owed       <= 1'b0;
    end else begin
      state          <= next_state;
      elem_valid_o   <= next_valid;
      elem_type_o    <= next_type;
      elem_addr_o    <= next_addr;
      elem_iset_o    <= next_iset;
      elem_payload_o <= next_payload;
      elem_ctx_o     <= next_ctx;
      elem_unknown_o <= next_unknown;
      first_done     <= next_first_done;
      last_ctx       <= next_last_ctx;
      ctx_owed       <= next_ctx_owed;
    end
  end

  // Time of the latest flow element and of the last marker; zero stays unknown
  always_comb begin
    next_flow_time = flow_time;
    next_mark_time = mark_time;
    next_mark_seen = mark_seen;
    if (take && is_flow) begin
      next_flow_time = ts_now;
    end
    if (state == st_on) begin
      next_mark_seen = 1'b0;
    end
    // A marker in the same cycle as the restart clear still counts
    if (core_ts_mark_i) begin
      next_mark_time = next_flow_time;
      next_mark_seen = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      flow_time <= 64'h0;
      mark_time <= 64'h0;
      mark_seen <= 1'b0;
    end else begin
      flow_time <= next_flow_time;
      mark_time <= next_mark_time;
      mark_seen <= next_mark_seen;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  logic emit;
  assign emit = elem_valid_o && elem_ready_i;

  chk_reset_exc: assert property (
    emit && elem_type_o == el_exception && elem_payload_o[7:0] == EXC_PE_RESET
    |-> elem_unknown_o && elem_addr_o == '0)
    else $error("reset exception without unknown address");

  chk_on_target: assert property (
    state == st_on && out_free && tracing && !core_gap_i && !core_warm_reset_i
    |-> ##[1:60] state == st_tgt)
    else $error("trace-on not followed by target");

  chk_first_ctx: assert property (
    state == st_on && !first_done && out_free && tracing && !core_gap_i
    && !core_warm_reset_i |=> state == st_ctx)
    else $error("first trace-on without context");

  chk_atom_type: assert property (
    take && core_kind_i == ck_atom |=> elem_valid_o
    && elem_type_o == (($past(core_taken_i)) ? el_atom_e : el_atom_n))
    else $error("atom type does not follow branch outcome");

  chk_count_unknown: assert property (
    take && core_kind_i == ck_count |=> elem_unknown_o == !$past(core_count_known_i))
    else $error("count known flag wrong");

  chk_ctx_after_cnt: assert property (
    take && core_kind_i == ck_count && core_new_ctx_i |=> ctx_owed)
    else $error("context not owed after count");

  chk_cc_follows: assert property (
    take && core_kind_i == ck_commit && core_cc_i |=> state == st_cc)
    else $error("cycle count not queued after commit");

  chk_ts_source: assert property (
    take && core_kind_i == ck_ts && !(ctrl[CTRL_V11_BIT] && mark_seen)
    |=> elem_payload_o == $past(flow_time))
    else $error("timestamp not from latest flow element");

  chk_ts_marker: assert property (
    take && core_kind_i == ck_ts && ctrl[CTRL_V11_BIT] && mark_seen
    |=> elem_payload_o == $past(mark_time))
    else $error("timestamp not from marker");

  chk_warm_reset: assert property (
    core_warm_reset_i && tracing && state != st_idle |=> state == st_reset)
    else $error("warm reset did not raise exception");

  cov_trace_on: cover property (emit && elem_type_o == el_trace_on);
  cov_count_ctx: cover property (take && core_kind_i == ck_count && core_new_ctx_i);
  cov_cc: cover property (emit && elem_type_o == el_cyc_count);
  cov_reset: cover property (emit && elem_type_o == el_exception && elem_unknown_o);

endmodule
`default_nettype wire

// ### testbench/teg_encoder_model.sv
`timescale 1ns/1ps
`default_nettype none
module teg_encoder_model
  import teg_pkg::*;
#(
  parameter int AW = 64
) (
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          reset_i,
  // Pace control
  input  wire logic          stall_i,
  // Element stream from the generator
  input  wire logic          elem_valid_i,
  input  wire teg_elem_t     elem_type_i,
  input  wire logic [AW-1:0] elem_addr_i,
  input  wire logic [1:0]    elem_iset_i,
  input  wire logic [63:0]   elem_payload_i,
  input  wire logic [3:0]    elem_ctx_i,
  input  wire logic          elem_unknown_i,
  output logic               elem_ready_o
);
  typedef struct {
    teg_elem_t     ty;
    logic [AW-1:0] ad;
    logic [1:0]    is;
    logic [63:0]   pl;
    logic [3:0]    cx;
    logic          un;
  } teg_rec_t;

  teg_rec_t   q[$];
  int         n_got = 0;
  logic [1:0] pace = 2'h0;

  // A stalled encoder is ready one cycle in four, so held outputs get exercised
  always @(posedge mclk_i) begin
    if (reset_i) begin
      pace <= 2'h0;
      elem_ready_o <= 1'b0;
    end else begin
      if (elem_valid_i && elem_ready_o) begin
        q.push_back('{elem_type_i, elem_addr_i, elem_iset_i, elem_payload_i, elem_ctx_i, elem_unknown_i});
        n_got++;
      end
      pace <= pace + 2'h1;
      elem_ready_o <= !stall_i || (pace == 2'h3);
    end
  end
endmodule
`default_nettype wire

// ### testbench/teg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module teg_top_tb;
  import teg_pkg::*;
  logic        mclk_i = 1'b0, reset_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, d;
  logic        core_valid_i = 1'b0, core_taken_i = 1'b0, core_count_known_i = 1'b0, core_new_ctx_i = 1'b0;
  logic        core_cc_i = 1'b0, core_ready_o, core_active_i = 1'b1, core_gap_i = 1'b0;
  logic        core_warm_reset_i = 1'b0, core_ts_mark_i = 1'b0, ctx_secure_i = 1'b1, ctx_wide_i = 1'b1;
  teg_kind_t   core_kind_i = ck_atom;
  logic [63:0] core_addr_i = 64'h0, core_next_addr_i = 64'h1000, ts_phys_i = 64'h100, ts_virt_i = 64'h9000;
  logic [1:0]  core_iset_i = ISET_MIXED, core_next_iset_i = ISET_NARROW, ctx_level_i = 2'h2;
  logic [7:0]  core_count_i = 8'h05, core_exc_type_i = 8'h00;
  logic [31:0] ctx_id_i = 32'h11, ctx_vid_i = 32'h22;
  logic        elem_valid_o, elem_ready_i, elem_unknown_o, stall = 1'b0;
  teg_elem_t   elem_type_o, r_ty;
  logic [63:0] elem_addr_o, elem_payload_o, r_ad, r_pl;
  logic [1:0]  elem_iset_o, r_is;
  logic [3:0]  elem_ctx_o, r_cx;
  logic        r_un;
  int          n_mismatch = 0, n_compared = 0, cycles = 0, t_cc = 0;

  teg_top teg_top_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .core_valid_i(core_valid_i),
    .core_kind_i(core_kind_i), .core_taken_i(core_taken_i), .core_addr_i(core_addr_i),
    .core_iset_i(core_iset_i), .core_count_i(core_count_i), .core_count_known_i(core_count_known_i),
    .core_new_ctx_i(core_new_ctx_i), .core_exc_type_i(core_exc_type_i), .core_cc_i(core_cc_i),
    .core_ready_o(core_ready_o), .core_active_i(core_active_i), .core_gap_i(core_gap_i),
    .core_warm_reset_i(core_warm_reset_i), .core_ts_mark_i(core_ts_mark_i),
    .core_next_addr_i(core_next_addr_i), .core_next_iset_i(core_next_iset_i), .ctx_secure_i(ctx_secure_i),
    .ctx_level_i(ctx_level_i), .ctx_wide_i(ctx_wide_i), .ctx_id_i(ctx_id_i), .ctx_vid_i(ctx_vid_i),
    .ts_phys_i(ts_phys_i), .ts_virt_i(ts_virt_i), .elem_valid_o(elem_valid_o), .elem_ready_i(elem_ready_i),
    .elem_type_o(elem_type_o), .elem_addr_o(elem_addr_o), .elem_iset_o(elem_iset_o),
    .elem_payload_o(elem_payload_o), .elem_ctx_o(elem_ctx_o), .elem_unknown_o(elem_unknown_o)
  );

  teg_encoder_model teg_encoder_model_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .stall_i(stall), .elem_valid_i(elem_valid_o),
    .elem_type_i(elem_type_o), .elem_addr_i(elem_addr_o), .elem_iset_i(elem_iset_o),
    .elem_payload_i(elem_payload_o), .elem_ctx_i(elem_ctx_o), .elem_unknown_i(elem_unknown_o),
    .elem_ready_o(elem_ready_i)
  );

  always #5 mclk_i = ~mclk_i;

  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under a thousand cycles
  // Non-blocking so that tasks reading it right after an edge see one stable value
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= v;
    sel_i <= 4'hf;
    do @(posedge mclk_i); while (ack_o !== 1'b1);
    d = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic req(input teg_kind_t k);
    @(posedge mclk_i);
    core_valid_i <= 1'b1;
    core_kind_i <= k;
    do @(posedge mclk_i); while (core_ready_o !== 1'b1);
    core_valid_i <= 1'b0;
  endtask

  // Waits a bounded time for the next captured element; optionally skips a context element
  task automatic get(input teg_elem_t t, input logic skip);
    int i;
    i = 0;
    do begin
      while (teg_encoder_model_inst.q.size() == 0 && i < 200) begin
        @(posedge mclk_i);
        i++;
      end
      r_ty = teg_elem_t'(4'hf);
      if (teg_encoder_model_inst.q.size() != 0) begin
        r_ty = teg_encoder_model_inst.q[0].ty;
        r_ad = teg_encoder_model_inst.q[0].ad;
        r_is = teg_encoder_model_inst.q[0].is;
        r_pl = teg_encoder_model_inst.q[0].pl;
        r_cx = teg_encoder_model_inst.q[0].cx;
        r_un = teg_encoder_model_inst.q[0].un;
        void'(teg_encoder_model_inst.q.pop_front());
      end
    end while (skip && r_ty == el_context);
    `CHK(r_ty, t)
  endtask

  initial begin
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    wb(1'b0, REG_ID, 32'h0);
    `CHK(d[0], 1'b1)
    wb(1'b0, 8'h40, 32'h0);
    `CHK(d, 32'h0)
    wb(1'b1, REG_CTRL, 32'h1);
    get(el_trace_on, 1'b0);
    get(el_context, 1'b0);
    `CHK(r_cx, 4'hd)
    get(el_target, 1'b0);
    `CHK({r_ad, r_is}, {64'h1000, ISET_NARROW})
    core_addr_i <= 64'h2000;
    req(ck_src);
    get(el_src_addr, 1'b0);
    `CHK({r_ad, r_is}, {64'h2000, ISET_MIXED})
    for (int t = 1; t >= 0; t--) begin
      core_taken_i <= t[0];
      req(ck_atom);
      get(t ? el_atom_e : el_atom_n, 1'b0);
    end
    core_exc_type_i <= 8'h07;
    req(ck_exc);
    get(el_exception, 1'b0);
    `CHK({r_pl, r_un}, {64'h7, 1'b0})
    // Back-to-back counts against a stalling encoder keep their order
    stall <= 1'b1;
    core_count_known_i <= 1'b1;
    req(ck_count);
    core_count_known_i <= 1'b0;
    req(ck_count);
    get(el_count, 1'b0);
    `CHK({r_pl, r_un}, {64'h5, 1'b0})
    get(el_count, 1'b0);
    `CHK(r_un, 1'b1)
    ts_phys_i <= 64'h200;
    req(ck_ts);
    get(el_timestamp, 1'b0);
    `CHK(r_pl, 64'h100)
    ts_phys_i <= 64'h0;
    req(ck_atom);
    get(el_atom_n, 1'b0);
    ts_phys_i <= 64'h500;
    req(ck_ts);
    get(el_timestamp, 1'b0);
    `CHK(r_pl, 64'h0)
    wb(1'b1, REG_CTRL, 32'h5);
    req(ck_atom);
    req(ck_ts);
    get(el_atom_n, 1'b0);
    get(el_timestamp, 1'b0);
    `CHK(r_pl, 64'h9000)
    wb(1'b1, REG_CTRL, 32'h3);
    ts_phys_i <= 64'h300;
    req(ck_src);
    get(el_src_addr, 1'b0);
    core_ts_mark_i <= 1'b1;
    @(posedge mclk_i);
    core_ts_mark_i <= 1'b0;
    ts_phys_i <= 64'h400;
    req(ck_atom);
    req(ck_ts);
    get(el_atom_n, 1'b0);
    get(el_timestamp, 1'b0);
    `CHK(r_pl, 64'h300)
    // Counted, uncounted, counted: the second count spans the two counted commits
    core_cc_i <= 1'b1;
    req(ck_commit);
    t_cc = cycles;
    core_cc_i <= 1'b0;
    req(ck_commit);
    core_cc_i <= 1'b1;
    req(ck_commit);
    t_cc = cycles - t_cc;
    core_cc_i <= 1'b0;
    req(ck_tstart);
    get(el_commit, 1'b0);
    get(el_cyc_count, 1'b0);
    get(el_commit, 1'b0);
    get(el_commit, 1'b0);
    get(el_cyc_count, 1'b0);
    `CHK(r_pl, 64'(t_cc))
    get(el_tstart, 1'b0);
    stall <= 1'b0;
    ctx_level_i <= 2'h1;
    core_next_addr_i <= 64'h3000;
    core_new_ctx_i <= 1'b1;
    req(ck_count);
    core_new_ctx_i <= 1'b0;
    get(el_count, 1'b0);
    get(el_target, 1'b0);
    `CHK(r_ad, 64'h3000)
    get(el_context, 1'b0);
    `CHK(r_cx, 4'hb)
    core_gap_i <= 1'b1;
    @(posedge mclk_i);
    core_gap_i <= 1'b0;
    get(el_trace_on, 1'b0);
    get(el_target, 1'b1);
    core_warm_reset_i <= 1'b1;
    @(posedge mclk_i);
    core_warm_reset_i <= 1'b0;
    get(el_exception, 1'b0);
    `CHK(r_pl[7:0], EXC_PE_RESET)
    `CHK({r_ad, r_un}, {64'h0, 1'b1})
    get(el_trace_on, 1'b0);
    get(el_target, 1'b1);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(d[6:4], 3'b011)
    wb(1'b0, REG_COUNT, 32'h0);
    `CHK(d, 32'(teg_encoder_model_inst.n_got))
    final_report();
  end
endmodule
`default_nettype wire
